// [src/vps_pkg.sv]
package vps_pkg;

	// ****************************************************************
	// Vector area and stacking constants.
	// ****************************************************************
	localparam logic [15:0] VEC_AREA_BASE    = 16'hFFCC;
	localparam logic [15:0] VEC_AREA_TOP     = 16'hFFFF;
	localparam logic [15:0] VEC_SWI_ADDR     = 16'hFFFC;
	localparam logic [15:0] VEC_RESET_ADDR   = 16'hFFFE;
	localparam logic [15:0] SP_RESET_VALUE   = 16'h00FF;
	localparam logic [15:0] STATUS_FOUR_ADDR = 16'hFE07;
	localparam int          NUM_SOURCES      = 24;
	localparam logic [2:0]  INT_STACK_BYTES  = 3'h5;
	localparam logic [2:0]  CALL_STACK_BYTES = 3'h2;

	// ****************************************************************
	// Stacking operation kinds.
	// ****************************************************************
	typedef enum logic [1:0] {
		VPS_OP_NONE,
		VPS_OP_INTERRUPT,
		VPS_OP_CALL
	} vps_op_t;

	typedef enum {
		VPS_IDLE,
		VPS_PUSH,
		VPS_FETCH_HI,
		VPS_FETCH_LO,
		VPS_DONE
	} vps_state_t;

endpackage

// [src/vps_sync.sv]
`timescale 1ns/10ps
// Two-flop reset release; assertion is asynchronous, release is clocked.
module vps_sync (
	// Clock and raw reset.
	input  wire logic clk,
	input  wire logic rst_n,
	// Released reset.
	output logic      rst_sync_n
);

	logic meta_reg;

	// Reset release chain.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_reg   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			meta_reg   <= 1'b1;
			rst_sync_n <= meta_reg;
		end
	end

endmodule

// [src/vps_top.sv]
`timescale 1ns/10ps
// Behaviour
// - Timer two channel 5 vectors at FFCC, lowest.
// - Timer two channels 4,3,2 at FFCE..FFD2.
// - CAN tx,rx,error,wakeup at FFD4..FFDA.
// - Timebase, converter, keyboard at FFDC..FFE0.
// - Serial link tx,rx,error at FFE2..FFE6.
// - SPI transmit FFE8, receive FFEA.
// - Timer two overflow,ch1,ch0 at FFEC..FFF0.
// - Timer one, clock loop, external pin FFF2..FFFA.
// - Vector fetches only from FFCC..FFFF.
// - Interrupt entry pushes five bytes.
// - Index high byte never stacked.
// - Call pushes two; SP down push, up pull.
// - Sixteen-bit SP resets to 00FF.
// - Status four bits 1,0 show flags 24,23.
module vps_top (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Pending sources, bit n-1 is flag n (bit 0 highest rank).
	input  wire logic [23:0] irq_pending,
	input  wire logic        software_interrupt,
	// Core requests.
	input  wire logic        int_enable,
	input  wire logic        call_req,
	input  wire logic        pull_req,
	// Bytes the core offers for stacking: PC lo, PC hi, X, A, CCR.
	input  wire logic [7:0]  stack_data [5],
	// Index high byte, held but never stacked.
	input  wire logic [7:0]  index_high,
	// Stack and vector bus toward memory.
	output logic             mem_we,
	output logic             mem_re,
	output logic [15:0]      mem_addr,
	output logic [7:0]       mem_wdata,
	input  wire logic [7:0]  mem_rdata,
	// Results.
	output logic [15:0]      stack_ptr,
	output logic [15:0]      vector_out,
	output logic             vector_valid,
	output logic             busy,
	output logic [7:0]       interrupt_status_four
);

	// ****************************************************************
	// Reset release.
	// ****************************************************************
	logic rst_sync_n;

	vps_sync u_sync (
		.clk        (clk),
		.rst_n      (rst_n),
		.rst_sync_n (rst_sync_n)
	);

	// ****************************************************************
	// Priority encoding.
	// ****************************************************************
	logic [15:0] sel_addr;
	logic        any_req;
	logic [4:0]  sel_idx;

	// Lowest flag number wins; flag n sits at FFFA - 2*(n-1), so flag 24 lands on FFCC.
	// lowest at base
	always_comb begin
		sel_idx  = 5'h00;
		any_req  = 1'b0;
		sel_addr = vps_pkg::VEC_SWI_ADDR;
		if (software_interrupt) begin
			any_req  = 1'b1;
			sel_addr = vps_pkg::VEC_SWI_ADDR;
		end else begin
			for (int i = vps_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
				if (irq_pending[i] && int_enable) begin
					any_req = 1'b1;
					sel_idx = 5'(i);
				end
			end
			sel_addr = vps_pkg::VEC_SWI_ADDR - 16'h0002 - {10'h000, sel_idx, 1'b0};
		end
	end

	// ****************************************************************
	// Sequencer.
	// ****************************************************************
	vps_pkg::vps_state_t state_reg;
	vps_pkg::vps_op_t    op_reg;
	logic [2:0]          cnt_reg;
	logic [15:0]         vec_addr_reg;
	logic [7:0]          vec_hi_reg;

	// One byte per cycle; the memory answers reads in the same cycle.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			state_reg    <= vps_pkg::VPS_FETCH_HI;
			op_reg       <= vps_pkg::VPS_OP_NONE;
			cnt_reg      <= 3'h0;
			vec_addr_reg <= vps_pkg::VEC_RESET_ADDR;
		end else begin
			case (state_reg)
				vps_pkg::VPS_IDLE: begin
					if (any_req) begin
						op_reg       <= vps_pkg::VPS_OP_INTERRUPT;
						cnt_reg      <= vps_pkg::INT_STACK_BYTES;
						vec_addr_reg <= sel_addr;
						state_reg    <= vps_pkg::VPS_PUSH;
					end else if (call_req) begin
						op_reg    <= vps_pkg::VPS_OP_CALL;
						cnt_reg   <= vps_pkg::CALL_STACK_BYTES;
						state_reg <= vps_pkg::VPS_PUSH;
					end
				end
				vps_pkg::VPS_PUSH: begin
					cnt_reg <= cnt_reg - 3'h1;
					if (cnt_reg == 3'h1 && op_reg == vps_pkg::VPS_OP_INTERRUPT) begin
						state_reg <= vps_pkg::VPS_FETCH_HI;
					end else if (cnt_reg == 3'h1) begin
						state_reg <= vps_pkg::VPS_DONE;
					end
				end
				vps_pkg::VPS_FETCH_HI: state_reg <= vps_pkg::VPS_FETCH_LO;
				vps_pkg::VPS_FETCH_LO: state_reg <= vps_pkg::VPS_DONE;
				default: begin
					op_reg    <= vps_pkg::VPS_OP_NONE;
					state_reg <= vps_pkg::VPS_IDLE;
				end
			endcase
		end
	end

	// Stack pointer moves down per push, up per pull.
	// reset to 00FF
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			stack_ptr <= vps_pkg::SP_RESET_VALUE;
		end else if (state_reg == vps_pkg::VPS_PUSH) begin
			stack_ptr <= stack_ptr - 16'h0001;
		end else if (state_reg == vps_pkg::VPS_IDLE && pull_req && !any_req && !call_req) begin
			stack_ptr <= stack_ptr + 16'h0001;
		end
	end

	// High byte comes from the lower address.
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			vec_hi_reg   <= 8'h00;
			vector_out   <= 16'h0000;
			vector_valid <= 1'b0;
		end else begin
			vector_valid <= 1'b0;
			if (state_reg == vps_pkg::VPS_FETCH_HI) begin
				vec_hi_reg <= mem_rdata;
			end
			if (state_reg == vps_pkg::VPS_FETCH_LO) begin
				vector_out   <= {vec_hi_reg, mem_rdata};
				vector_valid <= 1'b1;
			end
		end
	end

	// Memory strobes. The index high byte is deliberately absent from the push mux.
	// index high excluded
	always_comb begin
		mem_we    = (state_reg == vps_pkg::VPS_PUSH);
		mem_re    = 1'b0;
		mem_addr  = stack_ptr;
		mem_wdata = (cnt_reg != 3'h0) ? stack_data[vps_pkg::INT_STACK_BYTES - cnt_reg] : 8'h00;
		if (state_reg == vps_pkg::VPS_FETCH_HI || state_reg == vps_pkg::VPS_FETCH_LO) begin
			mem_re   = (vec_addr_reg >= vps_pkg::VEC_AREA_BASE);
			mem_addr = vec_addr_reg | {15'h0000, state_reg == vps_pkg::VPS_FETCH_LO};
		end
	end

	assign busy = (state_reg != vps_pkg::VPS_IDLE);

	// Status view of the two lowest-rank pending flags.
	// status four bits
	always_ff @(posedge clk or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			interrupt_status_four <= 8'h00;
		end else begin
			interrupt_status_four <= {6'h00, irq_pending[23], irq_pending[22]};
		end
	end

	// ****************************************************************
	// Assertions.
	// ****************************************************************
	logic unused_ok;
	assign unused_ok = ^index_high;

	int_push_count_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(state_reg == vps_pkg::VPS_IDLE && any_req) |=> mem_we [*5] ##1 !mem_we)
		else $error("interrupt entry did not push five bytes");
	call_push_count_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(state_reg == vps_pkg::VPS_IDLE && !any_req && call_req) |=> mem_we [*2] ##1 !mem_we)
		else $error("call did not push two bytes");
	sp_push_dec_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		mem_we |=> stack_ptr == $past(stack_ptr) - 16'h0001)
		else $error("stack pointer did not decrement on push");
	vec_area_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		mem_re |-> mem_addr >= vps_pkg::VEC_AREA_BASE)
		else $error("vector fetch outside vector area");
	lowest_vec_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(state_reg == vps_pkg::VPS_IDLE && irq_pending == 24'h800000 && int_enable
		&& !software_interrupt) |=> vec_addr_reg == vps_pkg::VEC_AREA_BASE)
		else $error("lowest source not at vector base");
	top_prio_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		(!software_interrupt && irq_pending[0] && int_enable) |-> sel_addr == 16'hFFFA)
		else $error("external pin request not ranked first");
	swi_vec_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		software_interrupt |-> sel_addr == vps_pkg::VEC_SWI_ADDR)
		else $error("software interrupt vector wrong");
	status_four_a: assert property (@(posedge clk) disable iff (!rst_sync_n)
		##1 interrupt_status_four == {6'h00, $past(irq_pending[23]), $past(irq_pending[22])})
		else $error("status four mismatch");
	vec_valid_c: cover property (@(posedge clk) disable iff (!rst_sync_n) vector_valid);
	call_c: cover property (@(posedge clk) disable iff (!rst_sync_n)
		op_reg == vps_pkg::VPS_OP_CALL);
	pull_c: cover property (@(posedge clk) disable iff (!rst_sync_n)
		state_reg == vps_pkg::VPS_IDLE && pull_req);

endmodule

// [testbench/tb_top.sv]
`timescale 1ns/10ps
module tb_top;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [23:0] irq_pending = 24'h0;
	logic        software_interrupt = 1'b0;
	logic        int_enable = 1'b0;
	logic        call_req = 1'b0;
	logic        pull_req = 1'b0;
	logic [7:0]  stack_data [5] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
	logic [7:0]  index_high = 8'hEE;
	logic        mem_we, mem_re, vector_valid, busy;
	logic [15:0] mem_addr, stack_ptr, vector_out;
	logic [15:0] fetch_addr = 16'h0;
	logic [7:0]  mem_wdata, mem_rdata, interrupt_status_four;
	logic [7:0]  pushed [$];
	logic [15:0] sp0;
	int          n_errors = 0;
	int          cmp_count = 0;
	// Free-running clock at 100 MHz.
	always #5 clk = ~clk;
	vps_top u_vps_top (.clk(clk), .rst_n(rst_n), .irq_pending(irq_pending),
		.software_interrupt(software_interrupt), .int_enable(int_enable),
		.call_req(call_req), .pull_req(pull_req), .stack_data(stack_data),
		.index_high(index_high), .mem_we(mem_we), .mem_re(mem_re),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.stack_ptr(stack_ptr), .vector_out(vector_out),
		.vector_valid(vector_valid), .busy(busy),
		.interrupt_status_four(interrupt_status_four));
	vps_mem_model u_vps_mem_model (.clk(clk), .mem_re(mem_re),
		.mem_addr(mem_addr), .mem_rdata(mem_rdata));
	// Log pushed bytes and the first fetch address of each operation.
	always @(posedge clk) begin
		if (mem_we === 1'b1) begin
			pushed.push_back(mem_wdata);
		end
		if (mem_re === 1'b1 && fetch_addr === 16'h0) begin
			fetch_addr = mem_addr;
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// The model returns the low address byte scrambled; high byte sits at the even place.
	function automatic logic [15:0] exp_vec(input logic [15:0] a);
		return {a[7:0] ^ 8'h5A, (a[7:0] | 8'h01) ^ 8'h5A};
	endfunction
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 40 && busy !== 1'b0; i++) begin
			step();
		end
		chk({15'h0, busy}, 16'h0);
	endtask
	// Bounded wait for the one-cycle vector pulse; a hang shows up as a failed compare.
	task automatic wait_vec();
		for (int i = 0; i < 40 && vector_valid !== 1'b1; i++) begin
			step();
		end
	endtask
	task automatic t_irq(input logic [23:0] p, input logic sw, input logic [15:0] a);
		sp0 = stack_ptr;
		pushed.delete();
		fetch_addr = 16'h0;
		irq_pending = p;
		software_interrupt = sw;
		int_enable = 1'b1;
		wait_vec();
		irq_pending = 24'h0;
		software_interrupt = 1'b0;
		chk(fetch_addr, a);
		chk(vector_out, exp_vec(a));
		chk(sp0 - stack_ptr, 16'h5);
		chk(16'(pushed.size()), 16'h5);
		for (int i = 0; i < 5; i++) begin
			chk({8'h0, pushed[i]}, {8'h0, stack_data[i]});
		end
		wait_idle();
		$display("test irq %h done", a);
	endtask
	// Each flag alone in turn; flag n must land at FFFA minus twice (n - 1).
	task automatic t_flags(input int lo, input int hi);
		for (int n = lo; n <= hi; n++) begin
			t_irq(24'h1 << (n - 1), 1'b0, 16'hFFFA - 16'(2 * (n - 1)));
		end
	endtask
	// Everything at once: software request wins even with flags masked, call beats pull.
	task automatic t_order();
		sp0 = stack_ptr;
		fetch_addr = 16'h0;
		int_enable = 1'b0;
		irq_pending = 24'h000001;
		software_interrupt = 1'b1;
		call_req = 1'b1;
		pull_req = 1'b1;
		step();
		irq_pending = 24'h0;
		software_interrupt = 1'b0;
		call_req = 1'b0;
		pull_req = 1'b0;
		wait_vec();
		chk(fetch_addr, 16'hFFFC);
		chk(sp0 - stack_ptr, 16'h5);
		step();
		chk({15'h0, vector_valid}, 16'h0);
		wait_idle();
		sp0 = stack_ptr;
		call_req = 1'b1;
		pull_req = 1'b1;
		step();
		call_req = 1'b0;
		pull_req = 1'b0;
		wait_idle();
		chk(sp0 - stack_ptr, 16'h2);
		$display("test ordering done");
	endtask
	task automatic t_call_pull();
		sp0 = stack_ptr;
		pushed.delete();
		call_req = 1'b1;
		step();
		call_req = 1'b0;
		wait_idle();
		chk(sp0 - stack_ptr, 16'h2);
		chk({pushed[0], pushed[1]}, {stack_data[3], stack_data[4]});
		pull_req = 1'b1;
		step();
		pull_req = 1'b0;
		chk(stack_ptr, sp0 - 16'h1);
		$display("test call and pull done");
	endtask
	task automatic t_status();
		int_enable = 1'b0;
		irq_pending = 24'hC00000;
		repeat (3) step();
		chk({8'h0, interrupt_status_four}, 16'h0003);
		chk({15'h0, busy}, 16'h0);
		irq_pending = 24'h0;
		$display("test status done");
	endtask
	task automatic close_out();
		$display("compares %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// Watchdog sized well past the few hundred cycles the tests need.
	initial begin
		#50000;
		n_errors++;
		close_out();
	end
	// Hold reset, check the reset state, then release and follow the reset vector fetch.
	task automatic t_reset(input int hold);
		rst_n = 1'b0;
		repeat (hold) step();
		chk(stack_ptr, 16'h00FF);
		chk({8'h0, interrupt_status_four}, 16'h0);
		chk(vector_out, 16'h0);
		fetch_addr = 16'h0;
		rst_n = 1'b1;
		wait_vec();
		chk(fetch_addr, 16'hFFFE);
		chk(vector_out, exp_vec(16'hFFFE));
		wait_idle();
		$display("test reset done");
	endtask
	// Main sequence: reset, vector table, priority, ordering, stacking, status, reset again.
	initial begin
		t_reset(10);
		t_flags(1, 5);
		t_flags(6, 8);
		t_flags(9, 10);
		t_flags(11, 13);
		t_flags(14, 16);
		t_flags(17, 20);
		t_flags(21, 23);
		t_flags(24, 24);
		t_irq(24'hC00000, 1'b0, 16'hFFCE);
		t_irq(24'hFFFFFF, 1'b0, 16'hFFFA);
		t_irq(24'hFFFFFF, 1'b1, 16'hFFFC);
		t_order();
		t_call_pull();
		t_status();
		t_reset(3);
		close_out();
	end
endmodule

// [testbench/vps_mem_model.sv]
`timescale 1ns/10ps
// ****************************************************************
// Vector store model.
// ****************************************************************
module vps_mem_model (
	// Clock.
	input  wire logic        clk,
	// Fetch bus.
	input  wire logic        mem_re,
	input  wire logic [15:0] mem_addr,
	output logic [7:0]       mem_rdata
);
	logic [7:0] last_reg = 8'h00;
	// Answer in the same cycle; an idle bus shows the inverse of the last byte.
	always_comb begin
		mem_rdata = mem_re ? (mem_addr[7:0] ^ 8'h5A) : ~last_reg;
	end
	// Keep the last byte driven so stale data never reads as a match.
	always @(posedge clk) begin
		if (mem_re) begin
			last_reg <= mem_rdata;
		end
	end
endmodule
